// >>> rtl/eslc_top.sv
// Purpose: Enhanced status indicator controller driving active-low indicator pins.
// Assumes: Core status inputs are synchronous to ref_clk; activity and collision are event levels.
// Notes: Notes on behaviour follow.
//
// Notes on behaviour
// [RQ1] Enhanced indicator behaviour only while legacy-mode bit is zero.
// [RQ2] Each pin follows its own function code; codes 7, 11, 13 reserved.
// [RQ3] Power-down forces every indicator off.
// [RQ4] Code 0: on with link at any speed; activity animates toward off.
// [RQ5] Codes 1, 2, 3: link only at 1000, 100, 10 megabit.
// [RQ6] Codes 4, 5, 6: link at 100/1000, 10/1000, 10/100 megabit.
// [RQ7] Code 8: on for full duplex; half-duplex collisions animate toward on.
// [RQ8] Code 9: off without collisions, animates toward on on collision.
// [RQ9] Code 10: activity animates toward on; select bit restricts to transmit.
// [RQ10] Code 12: on while an auto-negotiation fault is present.
// [RQ11] Code 14 forces off, code 15 forces on.
// [RQ12] Per-pin combine disable suppresses the secondary activity indication.
// [RQ13] Software sets behaviour bit 15 when writing the combine disables.
// [RQ14] Per-pin enable picks pulse-stretch instead of blink.
// [RQ15] Blink is 50% duty; one event shows half a period.
// [RQ16] Stretch shows a full period, holds after events, rests half period.
// [RQ17] Per-pin rate: blink 2.5 to 20 Hz, stretch 50 to 400 ms.
// [RQ18] Pulsing modulates asserted indicators at 5 kHz, 20% on.
// [RQ19] All timing comes from counters on the free-running reference clock.
`timescale 1ns/1ps
`default_nettype none

module eslc_top #(
    parameter int HALF_UNIT_CYC = eslc_pkg::HALF_UNIT_CYC,
    parameter int PULSE_PERIOD_CYC = eslc_pkg::PULSE_PERIOD_CYC,
    parameter int PULSE_ON_CYC = eslc_pkg::PULSE_ON_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [eslc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [eslc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [eslc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic link_up,
    input wire logic [1:0] link_speed,
    input wire logic full_duplex,
    input wire logic rx_activity,
    input wire logic tx_activity,
    input wire logic collision,
    input wire logic an_fault,
    output logic [eslc_pkg::N_LED-1:0] led_n
);

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [eslc_pkg::DATA_W-1:0] ctrl;
    logic [eslc_pkg::DATA_W-1:0] func_sel;
    logic [eslc_pkg::DATA_W-1:0] behavior;
    logic [eslc_pkg::DATA_W-1:0] status;
    logic [eslc_pkg::N_LED-1:0] ind_on;
    logic legacy;
    logic pdown;
    logic pulsing;
    logic act_tx_only;
    logic spd10;
    logic spd100;
    logic spd1000;
    logic act_any;
    logic [eslc_pkg::CNT_W-1:0] pulse_cnt;
    logic pulse_phase;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= eslc_pkg::CTRL_RST;
            func_sel <= eslc_pkg::FUNC_SEL_RST;
            behavior <= eslc_pkg::BEHAVIOR_RST;
        end else if (reg_wr) begin
            if (reg_addr == eslc_pkg::OFS_CTRL) begin
                ctrl <= reg_wdata & 16'h0003;
            end
            if (reg_addr == eslc_pkg::OFS_FUNC_SEL) begin
                func_sel <= reg_wdata;
            end
            // Bit 15 is kept as written; software sets it with the combine field.
            if (reg_addr == eslc_pkg::OFS_BEHAVIOR) begin
                behavior <= reg_wdata & eslc_pkg::BEH_MASK; // [RQ13]
            end
        end
    end

    assign status = {8'h00, ~legacy, an_fault, full_duplex, link_speed, link_up, ind_on};

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                eslc_pkg::OFS_CTRL: reg_rdata <= ctrl;
                eslc_pkg::OFS_FUNC_SEL: reg_rdata <= func_sel;
                eslc_pkg::OFS_BEHAVIOR: reg_rdata <= behavior;
                eslc_pkg::OFS_STATUS: reg_rdata <= status;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    assign legacy = ctrl[eslc_pkg::CTRL_LEGACY_BIT]; // [RQ1]
    assign pdown = ctrl[eslc_pkg::CTRL_PDOWN_BIT];
    assign pulsing = behavior[eslc_pkg::BEH_PULSING_BIT] & ~legacy;
    assign act_tx_only = behavior[eslc_pkg::BEH_ACT_TX_BIT] & ~legacy;
    assign spd10 = link_up && (link_speed == eslc_pkg::SPD_10);
    assign spd100 = link_up && (link_speed == eslc_pkg::SPD_100);
    assign spd1000 = link_up && (link_speed == eslc_pkg::SPD_1000);
    assign act_any = rx_activity | tx_activity;

    // ****************************************************************
    // Shared 5 kHz pulsing modulator.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_cnt <= '0;
        end else if (pulse_cnt == PULSE_PERIOD_CYC[eslc_pkg::CNT_W-1:0] - 1'b1) begin
            pulse_cnt <= '0; // [RQ19]
        end else begin
            pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    assign pulse_phase = pulse_cnt < PULSE_ON_CYC[eslc_pkg::CNT_W-1:0]; // [RQ18]

    // ****************************************************************
    // Per-pin function selection and animation.
    // ****************************************************************
    for (genvar i = 0; i < eslc_pkg::N_LED; i++) begin : g_led
        logic [eslc_pkg::SEL_W-1:0] code;
        logic [eslc_pkg::RATE_W-1:0] rate;
        logic comb;
        logic stretch;
        logic evt;
        logic ind;
        logic anim;
        logic pend;
        logic [eslc_pkg::CNT_W-1:0] cnt;
        logic [eslc_pkg::CNT_W-1:0] show_len;
        logic [eslc_pkg::CNT_W-1:0] rest_len;
        eslc_pkg::eslc_anim_e st;

        // Legacy mode: odd pins show link, even pins blink on activity.
        always_comb begin
            if (legacy) begin
                code = (i % 2 == 1) ? eslc_pkg::FN_LINK_ANY : eslc_pkg::FN_ACTIVITY; // [RQ1]
                comb = 1'b0;
                stretch = 1'b0;
                rate = eslc_pkg::RATE_LEGACY;
            end else begin
                code = func_sel[i*eslc_pkg::SEL_W +: eslc_pkg::SEL_W]; // [RQ2]
                comb = ~behavior[eslc_pkg::BEH_COMB_LSB + i]; // [RQ12]
                stretch = behavior[eslc_pkg::BEH_STRETCH_LSB + i]; // [RQ14]
                rate = behavior[eslc_pkg::BEH_RATE_LSB + i*eslc_pkg::RATE_W +: eslc_pkg::RATE_W];
            end
        end

        // Blink uses half periods of 200/100/50/25 ms; stretch shows 50 to 400 ms.
        always_comb begin
            if (stretch) begin
                show_len = HALF_UNIT_CYC[eslc_pkg::CNT_W-1:0] << ({1'b0, rate} + 3'h1); // [RQ17]
                rest_len = HALF_UNIT_CYC[eslc_pkg::CNT_W-1:0] << rate; // [RQ16]
            end else begin
                show_len = HALF_UNIT_CYC[eslc_pkg::CNT_W-1:0] << (2'(eslc_pkg::RATE_MAX) - rate);
                rest_len = show_len; // [RQ15]
            end
        end

        assign anim = (st == eslc_pkg::ANIM_SHOW);

        always_comb begin
            evt = 1'b0;
            ind = 1'b0;
            case (code)
                eslc_pkg::FN_LINK_ANY: begin
                    evt = link_up & comb & act_any;
                    ind = link_up & ~(comb & anim); // [RQ4]
                end
                eslc_pkg::FN_LINK_1000: begin
                    evt = spd1000 & comb & act_any;
                    ind = spd1000 & ~(comb & anim); // [RQ5]
                end
                eslc_pkg::FN_LINK_100: begin
                    evt = spd100 & comb & act_any;
                    ind = spd100 & ~(comb & anim); // [RQ5]
                end
                eslc_pkg::FN_LINK_10: begin
                    evt = spd10 & comb & act_any;
                    ind = spd10 & ~(comb & anim); // [RQ5]
                end
                eslc_pkg::FN_LINK_100_1000: begin
                    evt = (spd100 | spd1000) & comb & act_any;
                    ind = (spd100 | spd1000) & ~(comb & anim); // [RQ6]
                end
                eslc_pkg::FN_LINK_10_1000: begin
                    evt = (spd10 | spd1000) & comb & act_any;
                    ind = (spd10 | spd1000) & ~(comb & anim); // [RQ6]
                end
                eslc_pkg::FN_LINK_10_100: begin
                    evt = (spd10 | spd100) & comb & act_any;
                    ind = (spd10 | spd100) & ~(comb & anim); // [RQ6]
                end
                eslc_pkg::FN_DUPLEX_COLL: begin
                    evt = link_up & ~full_duplex & comb & collision;
                    ind = (link_up & full_duplex) | (link_up & ~full_duplex & comb & anim); // [RQ7]
                end
                eslc_pkg::FN_COLLISION: begin
                    evt = collision;
                    ind = anim; // [RQ8]
                end
                eslc_pkg::FN_ACTIVITY: begin
                    evt = act_tx_only ? tx_activity : act_any;
                    ind = anim; // [RQ9]
                end
                eslc_pkg::FN_AN_FAULT: begin
                    ind = an_fault; // [RQ10]
                end
                eslc_pkg::FN_FORCE_OFF: begin
                    ind = 1'b0; // [RQ11]
                end
                eslc_pkg::FN_FORCE_ON: begin
                    ind = 1'b1; // [RQ11]
                end
                default: begin
                    // Reserved codes leave the pin dark.
                    ind = 1'b0; // [RQ2]
                end
            endcase
        end

        // Show phase, then a rest phase in which new events queue for the next show.
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                st <= eslc_pkg::ANIM_IDLE;
                cnt <= '0;
                pend <= 1'b0;
            end else begin
                unique case (st)
                    eslc_pkg::ANIM_IDLE: begin
                        if (evt) begin
                            st <= eslc_pkg::ANIM_SHOW;
                            cnt <= show_len - 1'b1;
                        end
                    end
                    eslc_pkg::ANIM_SHOW: begin
                        if (stretch && evt) begin
                            cnt <= show_len - 1'b1; // [RQ16]
                        end else if (cnt == '0) begin
                            st <= eslc_pkg::ANIM_REST;
                            cnt <= rest_len - 1'b1;
                        end else begin
                            cnt <= cnt - 1'b1; // [RQ19]
                        end
                        if (!stretch) begin
                            pend <= pend | evt; // [RQ15]
                        end
                    end
                    eslc_pkg::ANIM_REST: begin
                        if (cnt == '0) begin
                            st <= (pend | evt) ? eslc_pkg::ANIM_SHOW : eslc_pkg::ANIM_IDLE;
                            cnt <= show_len - 1'b1;
                            pend <= 1'b0;
                        end else begin
                            cnt <= cnt - 1'b1;
                            pend <= pend | evt;
                        end
                    end
                endcase
            end
        end

        assign ind_on[i] = ind & ~pdown & (~pulsing | pulse_phase); // [RQ3] [RQ18]

        // Pins are active low; reset leaves them dark.
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                led_n[i] <= 1'b1;
            end else begin
                led_n[i] <= ~ind_on[i]; // [RQ3]
            end
        end
    end

endmodule

`default_nettype wire

// >>> common/eslc_pkg.sv
// Purpose: Shared constants and types of the enhanced status indicator controller.
// Assumes: 200 MHz reference clock; two indicator pins.
// Notes: Register offsets are byte addresses on the plain register port.
package eslc_pkg;

    // ****************************************************************
    // Geometry.
    // ****************************************************************
    localparam int N_LED = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SEL_W = 4;
    localparam int RATE_W = 2;
    localparam int CNT_W = 32;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FUNC_SEL = 8'h04;
    localparam logic [7:0] OFS_BEHAVIOR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int CTRL_LEGACY_BIT = 0;
    localparam int CTRL_PDOWN_BIT = 1;
    localparam int BEH_COMB_LSB = 0;
    localparam int BEH_STRETCH_LSB = 2;
    localparam int BEH_RATE_LSB = 4;
    localparam int BEH_ACT_TX_BIT = 12;
    localparam int BEH_PULSING_BIT = 13;
    localparam int BEH_LINK_ACT_BIT = 15;
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] FUNC_SEL_RST = 16'h00a0;
    localparam logic [15:0] BEHAVIOR_RST = 16'h0000;
    localparam logic [15:0] BEH_MASK = 16'hb0ff;
    localparam logic [1:0] RATE_LEGACY = 2'h2;

    // ****************************************************************
    // Function codes and link speed encoding.
    // ****************************************************************
    localparam logic [3:0] FN_LINK_ANY = 4'h0;
    localparam logic [3:0] FN_LINK_1000 = 4'h1;
    localparam logic [3:0] FN_LINK_100 = 4'h2;
    localparam logic [3:0] FN_LINK_10 = 4'h3;
    localparam logic [3:0] FN_LINK_100_1000 = 4'h4;
    localparam logic [3:0] FN_LINK_10_1000 = 4'h5;
    localparam logic [3:0] FN_LINK_10_100 = 4'h6;
    localparam logic [3:0] FN_DUPLEX_COLL = 4'h8;
    localparam logic [3:0] FN_COLLISION = 4'h9;
    localparam logic [3:0] FN_ACTIVITY = 4'ha;
    localparam logic [3:0] FN_AN_FAULT = 4'hc;
    localparam logic [3:0] FN_FORCE_OFF = 4'he;
    localparam logic [3:0] FN_FORCE_ON = 4'hf;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int HALF_UNIT_NS = 25000000;
    localparam int PULSE_PERIOD_NS = 200000;
    localparam int PULSE_ON_NS = 40000;
    localparam int HALF_UNIT_CYC = HALF_UNIT_NS / CLK_PERIOD_NS;
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PULSE_ON_CYC = PULSE_ON_NS / CLK_PERIOD_NS;
    localparam int RATE_MAX = 3;

    typedef enum logic [2:0] {
        ANIM_IDLE = 3'b001,
        ANIM_SHOW = 3'b010,
        ANIM_REST = 3'b100
    } eslc_anim_e;

endpackage

// >>> dv/eslc_led_model.sv
// Purpose: Indicator lamps hanging on the active-low indicator pins.
// Assumes: Each pin sinks current through its lamp, so a solid low lights it.
// Notes: A lamp has no memory; an unknown pin level gives an unknown lamp, never a lit one.
`timescale 1ns/1ps
`default_nettype none
module eslc_led_model (
    input wire logic [eslc_pkg::N_LED-1:0] led_n,
    output logic [eslc_pkg::N_LED-1:0] lit
);
    assign lit = ~led_n;
endmodule
`default_nettype wire

// >>> dv/eslc_top_monitor.sv
// Purpose: Port-level checker for the enhanced status indicator controller.
// Assumes: Register writes are shadowed from the register port; all signals on ref_clk.
// Notes: Run-length checks skip any lit run that overlaps a register write.
`timescale 1ns/1ps
`default_nettype none
module eslc_top_monitor #(
    parameter int HALF_UNIT_CYC = 4,
    parameter int PULSE_ON_CYC = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [eslc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [eslc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [eslc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic link_up,
    input wire logic [1:0] link_speed,
    input wire logic full_duplex,
    input wire logic rx_activity,
    input wire logic tx_activity,
    input wire logic collision,
    input wire logic an_fault,
    input wire logic [eslc_pkg::N_LED-1:0] led_n
);
    // ****************************************************************
    // Shadow of the settings and a lit-run counter for pin 0.
    // ****************************************************************
    logic [1:0] ctrl;
    logic [7:0] fsel;
    logic [15:0] beh;
    logic enh, clean;
    logic [3:0] fn0;
    int run;
    assign enh = !ctrl[0] && !ctrl[1];
    assign fn0 = fsel[3:0];
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= eslc_pkg::CTRL_RST[1:0];
            fsel <= eslc_pkg::FUNC_SEL_RST[7:0];
            beh <= eslc_pkg::BEHAVIOR_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                eslc_pkg::OFS_CTRL: ctrl <= reg_wdata[1:0];
                eslc_pkg::OFS_FUNC_SEL: fsel <= reg_wdata[7:0];
                eslc_pkg::OFS_BEHAVIOR: beh <= reg_wdata & eslc_pkg::BEH_MASK;
                default: ;
            endcase
        end
    end
    // A run is trusted only if no write landed since the pin was last dark.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run <= 0;
            clean <= 1'b0;
        end else begin
            run <= led_n[0] ? 0 : run + 1;
            clean <= !reg_wr && (clean || led_n[0]);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    status_mode_a: assert property ($past(reg_rd) && $past(reg_addr) == eslc_pkg::OFS_STATUS
        |-> reg_rdata[7] == !$past(ctrl[0])) else $error("mode flag in status wrong");
    legacy_link_a: assert property (ctrl == 2'b01
        |=> led_n[1] == !$past(link_up)) else $error("legacy link pin wrong");
    pdown_dark_a: assert property (ctrl[1] |=> led_n == 2'b11)
        else $error("pins lit during power-down");
    force_level_a: assert property (enh && !beh[13] && fn0 >= 4'he
        |=> led_n[0] == !$past(fsel[0])) else $error("forced level wrong");
    fault_pin_a: assert property (enh && !beh[13] && fn0 == eslc_pkg::FN_AN_FAULT
        |=> led_n[0] == !$past(an_fault)) else $error("fault indication wrong");
    reserved_off_a: assert property (enh && fn0 inside {4'h7, 4'hb, 4'hd} |=> led_n[0])
        else $error("reserved code lit the pin");
    link10_only_a: assert property (enh && !beh[13] && beh[0] && fn0 == eslc_pkg::FN_LINK_10
        |=> led_n[0] == !($past(link_up) && $past(link_speed) == eslc_pkg::SPD_10))
        else $error("ten megabit link pin wrong");
    duplex_on_a: assert property (enh && !beh[13] && beh[0] && fn0 == eslc_pkg::FN_DUPLEX_COLL
        |=> led_n[0] == !($past(link_up) && $past(full_duplex))) else $error("duplex pin wrong");
    blink_half_a: assert property ($rose(led_n[0]) && clean && enh && !beh[13] && !beh[2]
        && fn0 == eslc_pkg::FN_ACTIVITY |-> run == (HALF_UNIT_CYC << (2'd3 - beh[5:4])))
        else $error("blink half period wrong");
    pulse_on_a: assert property ($rose(led_n[0]) && clean && enh && beh[13]
        && fn0 == eslc_pkg::FN_FORCE_ON |-> run == PULSE_ON_CYC) else $error("pulsing on time wrong");
endmodule
bind eslc_top eslc_top_monitor #(
    .HALF_UNIT_CYC(HALF_UNIT_CYC),
    .PULSE_ON_CYC(PULSE_ON_CYC)
) u_eslc_top_monitor (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
    .link_speed(link_speed), .full_duplex(full_duplex), .rx_activity(rx_activity),
    .tx_activity(tx_activity), .collision(collision), .an_fault(an_fault), .led_n(led_n)
);
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the enhanced status indicator controller.
// Assumes: Shortened timing parameters so blink and pulse periods last a few cycles.
// Notes: Each scenario task drives the block and judges the lamps itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int HU = 4;
    logic ref_clk, rst_b, reg_wr, reg_rd, link_up, full_duplex;
    logic rx_activity, tx_activity, collision, an_fault;
    logic [eslc_pkg::ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [1:0] link_speed, led_n, lit;
    int error_cnt = 0;
    int n_compared = 0;
    eslc_top #(.HALF_UNIT_CYC(HU), .PULSE_PERIOD_CYC(10), .PULSE_ON_CYC(2)) u_eslc_top (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
        .link_speed(link_speed), .full_duplex(full_duplex), .rx_activity(rx_activity),
        .tx_activity(tx_activity), .collision(collision), .an_fault(an_fault), .led_n(led_n));
    eslc_led_model u_eslc_led_model (.led_n(led_n), .lit(lit));
    // ****************************************************************
    // Shared bus, stimulus and measuring tasks.
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        tick(1);
    endtask
    task automatic chk_lit(input logic [1:0] e);
        tick(3);
        #1;
        chk({14'h0000, lit}, {14'h0000, e});
        tick(1);
    endtask
    task automatic pulse(input logic tx);
        tx_activity <= tx;
        rx_activity <= !tx;
        tick(1);
        tx_activity <= 1'b0;
        rx_activity <= 1'b0;
    endtask
    // Bounded waits: a stuck pin ends the measurement instead of hanging the run.
    task automatic run_len(input logic lvl, output int n);
        int t;
        n = 0;
        t = 0;
        #1;
        while (lit[0] !== lvl && t < 40) begin
            tick(1);
            #1;
            t++;
        end
        while (lit[0] === lvl && n < 100) begin
            tick(1);
            #1;
            n++;
        end
        tick(1);
    endtask
    task automatic count_lit(input int w, output int n);
        n = 0;
        repeat (w) begin
            tick(1);
            #1;
            n += int'(lit[0] === 1'b1);
        end
        tick(1);
    endtask
    function automatic logic f_exp(input int c, input logic lu, input int s, input logic fd);
        logic [2:0] m [7];
        m = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h6, 3'h5, 3'h3};
        if (c < 7) begin
            return lu && m[c][s];
        end
        case (c)
            8: return lu && fd;
            12: return fd;
            15: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_regs();
        rd(eslc_pkg::OFS_CTRL, eslc_pkg::CTRL_RST);
        rd(eslc_pkg::OFS_FUNC_SEL, eslc_pkg::FUNC_SEL_RST);
        rd(eslc_pkg::OFS_STATUS, 16'h0000);
        rd(8'h10, 16'h0000);
        wr(eslc_pkg::OFS_BEHAVIOR, 16'hffff);
        rd(eslc_pkg::OFS_BEHAVIOR, 16'hb0ff);
        link_up <= 1'b1;
        chk_lit(2'b10);
        link_up <= 1'b0;
        chk_lit(2'b00);
        $display("test regs done");
    endtask
    task automatic t_codes();
        logic e;
        wr(eslc_pkg::OFS_CTRL, 16'h0000);
        rd(eslc_pkg::OFS_STATUS, 16'h0080);
        wr(eslc_pkg::OFS_BEHAVIOR, 16'h8003);
        for (int c = 0; c < 16; c++) begin
            for (int k = 0; k < 12; k++) begin
                link_up <= k[0];
                full_duplex <= k[1];
                an_fault <= k[1];
                link_speed <= 2'(k >> 2);
                wr(eslc_pkg::OFS_FUNC_SEL, {8'h00, 4'(c), 4'(c)});
                e = f_exp(c, k[0], k >> 2, k[1]);
                chk_lit({e, e});
            end
        end
        $display("test codes done");
    endtask
    task automatic t_anim();
        int n;
        wr(eslc_pkg::OFS_FUNC_SEL, 16'h00ea);
        for (int r = 0; r < 4; r++) begin
            wr(eslc_pkg::OFS_BEHAVIOR, 16'(r << 4));
            pulse(1'b1);
            run_len(1'b1, n);
            chk(16'(n), 16'(HU << (3 - r)));
            tick((HU << (3 - r)) + 2);
            wr(eslc_pkg::OFS_BEHAVIOR, 16'h0004 | 16'(r << 4));
            pulse(1'b1);
            run_len(1'b1, n);
            chk(16'(n), 16'(HU << (r + 1)));
            tick((HU << r) + 2);
        end
        wr(eslc_pkg::OFS_BEHAVIOR, 16'h1030);
        pulse(1'b0);
        count_lit(12, n);
        chk(16'(n), 16'h0000);
        $display("test animation done");
    endtask
    task automatic t_comb();
        int n;
        link_up <= 1'b1;
        link_speed <= eslc_pkg::SPD_1000;
        wr(eslc_pkg::OFS_FUNC_SEL, 16'h00e0);
        wr(eslc_pkg::OFS_BEHAVIOR, 16'h8030);
        pulse(1'b0);
        run_len(1'b0, n);
        chk(16'(n), 16'(HU));
        tick(HU + 2);
        wr(eslc_pkg::OFS_BEHAVIOR, 16'h8031);
        pulse(1'b0);
        count_lit(12, n);
        chk(16'(n), 16'd12);
        // Half-duplex link keeps code 8 dark until a collision lights it.
        full_duplex <= 1'b0;
        wr(eslc_pkg::OFS_BEHAVIOR, 16'h0030);
        for (int c = 8; c < 10; c++) begin
            wr(eslc_pkg::OFS_FUNC_SEL, 16'h00e0 | 16'(c));
            collision <= 1'b1;
            tick(1);
            collision <= 1'b0;
            run_len(1'b1, n);
            chk(16'(n), 16'(HU));
            tick(HU + 2);
        end
        rd(eslc_pkg::OFS_STATUS, 16'h00d4);
        $display("test combine done");
    endtask
    task automatic t_power();
        int n;
        wr(eslc_pkg::OFS_FUNC_SEL, 16'h00ff);
        wr(eslc_pkg::OFS_CTRL, 16'h0002);
        chk_lit(2'b00);
        wr(eslc_pkg::OFS_CTRL, 16'h0000);
        wr(eslc_pkg::OFS_BEHAVIOR, 16'h2000);
        count_lit(20, n);
        chk(16'(n), 16'd4);
        $display("test power done");
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_b, reg_wr, reg_rd, link_up, full_duplex, rx_activity} = '0;
        {tx_activity, collision, an_fault, reg_addr, reg_wdata, link_speed} = '0;
        tick(12);
        rst_b <= 1'b1;
        tick(1);
        t_regs();
        t_codes();
        t_anim();
        t_comb();
        t_power();
        close_out();
    end
    // The scenarios need well under 20 us; the limit leaves a wide margin.
    initial begin
        #60000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
